// ### mbs_pkg.sv
package mbs_pkg;

  // ==========================================================
  // Function codes and exception codes
  localparam logic [7:0] FN_READ = 8'h03;
  localparam logic [7:0] FN_WR1 = 8'h06;
  localparam logic [7:0] FN_WR1_VOL = 8'h41;
  localparam logic [7:0] FN_WRN = 8'h10;
  localparam logic [7:0] FN_WRN_KEEP = 8'h43;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_RANGE = 8'h03;
  localparam logic [7:0] EXC_FAIL = 8'h04;
  localparam logic [7:0] EXC_UNSUP = 8'h16;
  localparam logic [7:0] EXC_COUNT = 8'h17;
  localparam logic [7:0] EXC_FRAME = 8'h18;
  localparam logic [7:0] EXC_FIXED = 8'h20;
  localparam logic [7:0] EXC_RUNNING = 8'h21;
  localparam logic [7:0] EXC_PASSWORD = 8'h22;

  // ==========================================================
  // Frame layout and limits
  localparam logic [7:0] SLAVE_BCAST = 8'h00;
  localparam logic [15:0] READ_MAX = 16'h000C;
  localparam logic [15:0] WRN_MAX = 16'h0004;
  localparam logic [15:0] NUM_ZERO = 16'h0000;
  localparam int POS_SLAVE = 0;
  localparam int POS_FUNC = 1;
  localparam int POS_AHI = 2;
  localparam int POS_ALO = 3;
  localparam int POS_NHI = 4;
  localparam int POS_NLO = 5;
  localparam int POS_BC = 6;
  localparam int POS_WDATA = 7;
  localparam int POS_RBC = 2;
  localparam int POS_RDATA = 3;
  localparam int LEN_FIXED = 6;
  localparam int LEN_EXC = 3;
  localparam int READ_MAX_N = 12;

  // ==========================================================
  // Scaling offsets and register groups
  localparam logic [15:0] OFS_WIDE = 16'h03E8;
  localparam logic [15:0] OFS_NARROW = 16'h0064;
  localparam logic [15:0] OFS_NONE = 16'h0000;
  localparam logic [7:0] GRP_LAST = 8'h17;
  localparam logic [7:0] GRP_CTRL = 8'h32;
  localparam logic [7:0] GRP_STAT = 8'h33;

  // ==========================================================
  // Bus idle time before a reply, 3.5 characters of 11 bits
  localparam longint CLK_HZ = 25000000;
  localparam longint BAUD = 9600;
  localparam longint CHAR_BITS = 11;
  localparam longint IDLE_HALF_CHARS = 7;
  localparam longint IDLE_CYCLES_DEF = (IDLE_HALF_CHARS * CHAR_BITS * CLK_HZ + 2 * BAUD - 1) / (2 * BAUD);

  // ==========================================================
  // Decoding helpers
  function automatic logic fn_known(input logic [7:0] f);
    return f == FN_READ || f == FN_WR1 || f == FN_WR1_VOL || f == FN_WRN || f == FN_WRN_KEEP;
  endfunction : fn_known

  function automatic logic fn_multi(input logic [7:0] f);
    return f == FN_WRN || f == FN_WRN_KEEP;
  endfunction : fn_multi

  function automatic logic save_of(input logic [7:0] f, input logic sel);
    case (f)
      FN_WR1_VOL: return 1'b0;
      FN_WRN_KEEP: return 1'b1;
      default: return sel;
    endcase
  endfunction : save_of

  function automatic logic group_ok(input logic [7:0] g);
    case (g)
      8'h0C, 8'h0E, 8'h16: return 1'b0;
      GRP_CTRL, GRP_STAT: return 1'b1;
      default: return g <= GRP_LAST;
    endcase
  endfunction : group_ok

  function automatic logic [15:0] scale_offset(input logic [15:0] a);
    case (a)
      16'h0403, 16'h1501, 16'h1005, 16'h1008, 16'h100B, 16'h100E, 16'h1016, 16'h1018: return OFS_WIDE;
      16'h1006, 16'h1009: return OFS_NARROW;
      default: return OFS_NONE;
    endcase
  endfunction : scale_offset

endpackage : mbs_pkg

// ### mbs_mem_if.sv
`timescale 1ns/1ps
interface mbs_mem_if #(
  parameter int AW = 5,
  parameter int DW = 8
);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport user (output we, output waddr, output wdata, output raddr, input rdata);
  modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : mbs_mem_if

// ### mbs_frame_mem.sv
`timescale 1ns/1ps
// Frame byte store: holds the request, then the reply built over it.
module mbs_frame_mem #(
  parameter int DEPTH = 32,
  parameter int DW = 8
) (
  // Clock
  input wire logic clk,
  // Access port
  mbs_mem_if.store port
);
  logic [DW-1:0] cells [DEPTH];

  always_ff @(posedge clk) begin
    if (port.we) begin
      cells[port.waddr] <= port.wdata;
    end
    port.rdata <= cells[port.raddr];
  end
endmodule : mbs_frame_mem

// ### mbs_scale.sv
`timescale 1ns/1ps
// Converts between communication values and actual parameter values.
module mbs_scale
  import mbs_pkg::*;
(
  // Conversion request
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] value,
  input wire logic to_comm,
  // Result
  output logic [15:0] result,
  output logic out_of_range
);
  logic [15:0] ofs;

  always_comb begin
    ofs = scale_offset(reg_addr);
    result = to_comm ? value + ofs : value - ofs;
    out_of_range = !to_comm && ofs != OFS_NONE && value > {ofs[14:0], 1'b0};
  end
endmodule : mbs_scale

// ### mbs_slave.sv
// Operation
// - Wide signed parameters travel as 0..2000 meaning -1000..+1000.
// - Narrow signed parameters travel as 0..200 meaning -100..+100.
// - All other values travel unsigned in their resolution step.
// - Read uses 0x03, count 1..12; reply holds byte count and data.
// - Single write uses 0x06 or 0x41; reply echoes address and content.
// - Code 0x41 is never saved; 0x06 follows the save selection.
// - Multi write uses 0x10 or 0x43, count up to 4; reply echoes start, count.
// - Code 0x43 is always saved; 0x10 follows the save selection.
// - Multi write updates consecutive registers from the start address.
// - Registers are stored in ascending address order.
// - A failed store stops the write and is reported with the store's exception code.
// - A failure answers with function code plus 0x80 and an exception code.
// - Codes 0x01 function, 0x02 address, 0x03 limit, 0x04 slave fault.
// - Codes 0x16 unsupported, 0x17 bad count, 0x18 bad length or check.
// - Codes 0x20 fixed, 0x21 locked while running, 0x22 password protected.
// - Function, control and status parameters are 16-bit holding registers.
// - Register address is group in high byte, index in low byte.
// - High byte is the binary group number; listed groups are mapped.
// - Address 0 is broadcast; replies carry only the own address.
// - Multi-byte fields go most significant byte first.
// - Frames are separated by at least 3.5 character times of idle.
`timescale 1ns/1ps
module mbs_slave
  import mbs_pkg::*;
#(
  parameter int MEM_DEPTH = 32,
  parameter longint IDLE_CYCLES = IDLE_CYCLES_DEF
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // Configuration
  input wire logic [7:0] SLAVE_ADDR,
  input wire logic POWER_LOSS_SAVE_SELECT,
  // Received frame bytes
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_END,
  input wire logic RX_CHECK_OK,
  // Reply frame bytes
  output logic TX_VALID,
  output logic [7:0] TX_DATA,
  output logic TX_LAST,
  input wire logic TX_READY,
  // Parameter store access
  output logic PAR_REQ,
  output logic PAR_WRITE,
  output logic [15:0] PAR_ADDR,
  output logic [15:0] PAR_WDATA,
  output logic PAR_SAVE,
  input wire logic PAR_ACK,
  input wire logic [15:0] PAR_RDATA,
  input wire logic [7:0] PAR_EXC
);

  localparam int AW = $clog2(MEM_DEPTH);
  localparam int CW = AW + 1;
  localparam int IW = $clog2(IDLE_CYCLES + 1);
  localparam int MIN_DEPTH = POS_RDATA + 2 * READ_MAX_N;

  if (MEM_DEPTH < MIN_DEPTH || IDLE_CYCLES < 1) begin : g_bad_param
    $error("MEM_DEPTH must hold a full read reply and IDLE_CYCLES must be at least one");
  end

  typedef enum logic [3:0] {
    ST_RECV, ST_CHECK, ST_SETUP, ST_RDHI, ST_RDLO, ST_REQ, ST_WAIT,
    ST_WRHI, ST_WRLO, ST_NEXT, ST_HOLD, ST_TXLD, ST_TXPUT, ST_TXSEND
  } mbs_state_t;

  // ==========================================================
  // State
  mbs_state_t state, next_state;
  logic [CW-1:0] cnt, next_cnt;
  logic [7:0] slave, next_slave;
  logic [7:0] func, next_func;
  logic [7:0] bc, next_bc;
  logic [7:0] exc, next_exc;
  logic [7:0] data_hi, next_data_hi;
  logic [15:0] addr, next_addr;
  logic [15:0] num, next_num;
  logic [15:0] word, next_word;
  logic [3:0] idx, next_idx;
  logic chk_ok, next_chk_ok;
  logic [IW-1:0] idle_cnt, next_idle_cnt;
  logic [AW-1:0] tx_idx, next_tx_idx;
  logic [AW-1:0] tx_len, next_tx_len;
  logic tx_valid, next_tx_valid;
  logic [7:0] tx_data, next_tx_data;
  logic tx_last, next_tx_last;
  logic par_req, next_par_req;
  logic par_write, next_par_write;
  logic [15:0] par_addr, next_par_addr;
  logic [15:0] par_wdata, next_par_wdata;
  logic par_save, next_par_save;

  // ==========================================================
  // Helpers
  logic is_read;
  logic is_multi;
  logic [15:0] reg_addr;
  logic [AW-1:0] wbase;
  logic [AW-1:0] rbase;
  logic [15:0] sc_value;
  logic sc_to_comm;
  logic [15:0] sc_result;
  logic sc_oor;

  mbs_mem_if #(.AW(AW), .DW(8)) mem ();

  mbs_frame_mem #(.DEPTH(MEM_DEPTH), .DW(8)) u_mem (
    .clk(CORE_CLK),
    .port(mem.store)
  );

  mbs_scale u_scale (
    .reg_addr(reg_addr),
    .value(sc_value),
    .to_comm(sc_to_comm),
    .result(sc_result),
    .out_of_range(sc_oor)
  );

  assign is_read = func == FN_READ;
  assign is_multi = fn_multi(func);
  assign reg_addr = addr + 16'(idx);
  assign wbase = is_multi ? AW'(POS_WDATA + 2 * int'(idx)) : AW'(POS_NHI);
  assign rbase = AW'(POS_RDATA + 2 * int'(idx));
  assign sc_to_comm = state == ST_WAIT;
  assign sc_value = sc_to_comm ? PAR_RDATA : {data_hi, mem.rdata};

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [7:0] verdict;
    verdict = EXC_NONE;
    if (!chk_ok) begin
      verdict = EXC_FRAME;
    end else if (!fn_known(func)) begin
      verdict = EXC_FUNC;
    end else if (is_multi) begin
      if (num == NUM_ZERO || num > WRN_MAX || 16'(bc) != {num[14:0], 1'b0}) begin
        verdict = EXC_COUNT;
      end else if (16'(cnt) != 16'(POS_WDATA) + 16'(bc)) begin
        verdict = EXC_FRAME;
      end
    end else if (16'(cnt) != 16'(LEN_FIXED)) begin
      verdict = EXC_FRAME;
    end else if (is_read && (num == NUM_ZERO || num > READ_MAX)) begin
      verdict = EXC_COUNT;
    end
    if (verdict == EXC_NONE && !group_ok(addr[15:8])) begin
      verdict = EXC_ADDR;
    end

    next_state = state;
    next_cnt = cnt;
    next_slave = slave;
    next_func = func;
    next_bc = bc;
    next_exc = exc;
    next_data_hi = data_hi;
    next_addr = addr;
    next_num = num;
    next_word = word;
    next_idx = idx;
    next_chk_ok = chk_ok;
    next_idle_cnt = idle_cnt;
    next_tx_idx = tx_idx;
    next_tx_len = tx_len;
    next_tx_valid = tx_valid;
    next_tx_data = tx_data;
    next_tx_last = tx_last;
    next_par_req = par_req;
    next_par_write = par_write;
    next_par_addr = par_addr;
    next_par_wdata = par_wdata;
    next_par_save = par_save;
    mem.we = 1'b0;
    mem.waddr = '0;
    mem.wdata = 8'h00;
    mem.raddr = '0;
    if (idle_cnt != '0) begin
      next_idle_cnt = idle_cnt - 1'b1;
    end

    case (state)
      ST_RECV: begin
        if (RX_VALID) begin
          if (cnt < CW'(MEM_DEPTH)) begin
            mem.we = 1'b1;
            mem.waddr = cnt[AW-1:0];
            mem.wdata = RX_DATA;
            next_cnt = cnt + 1'b1;
          end
          case (int'(cnt))
            POS_SLAVE: next_slave = RX_DATA;
            POS_FUNC: next_func = RX_DATA;
            POS_AHI: next_addr[15:8] = RX_DATA;
            POS_ALO: next_addr[7:0] = RX_DATA;
            POS_NHI: next_num[15:8] = RX_DATA;
            POS_NLO: next_num[7:0] = RX_DATA;
            POS_BC: next_bc = RX_DATA;
            default: ;
          endcase
        end
        if (RX_END) begin
          next_chk_ok = RX_CHECK_OK;
          next_idle_cnt = IW'(IDLE_CYCLES);
          next_state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        next_cnt = '0;
        next_idx = 4'h0;
        next_exc = verdict;
        if (slave != SLAVE_ADDR && slave != SLAVE_BCAST) begin
          next_state = ST_RECV;
        end else if (verdict != EXC_NONE) begin
          next_state = ST_HOLD;
        end else if (is_read && slave == SLAVE_BCAST) begin
          next_state = ST_RECV;
        end else begin
          next_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (is_read) begin
          mem.we = 1'b1;
          mem.waddr = AW'(POS_RBC);
          mem.wdata = {num[6:0], 1'b0};
          next_state = ST_REQ;
        end else begin
          next_state = ST_RDHI;
        end
      end
      ST_RDHI: begin
        mem.raddr = wbase;
        next_state = ST_RDLO;
      end
      ST_RDLO: begin
        mem.raddr = wbase + 1'b1;
        next_data_hi = mem.rdata;
        next_state = ST_REQ;
      end
      ST_REQ: begin
        if (!is_read && sc_oor) begin
          next_exc = EXC_RANGE;
          next_state = ST_HOLD;
        end else begin
          next_par_req = 1'b1;
          next_par_write = !is_read;
          next_par_addr = reg_addr;
          next_par_wdata = sc_result;
          next_par_save = save_of(func, POWER_LOSS_SAVE_SELECT);
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (PAR_ACK) begin
          next_par_req = 1'b0;
          if (PAR_EXC != EXC_NONE) begin
            next_exc = PAR_EXC;
            next_state = ST_HOLD;
          end else if (is_read) begin
            next_word = sc_result;
            next_state = ST_WRHI;
          end else begin
            next_state = ST_NEXT;
          end
        end
      end
      ST_WRHI: begin
        mem.we = 1'b1;
        mem.waddr = rbase;
        mem.wdata = word[15:8];
        next_state = ST_WRLO;
      end
      ST_WRLO: begin
        mem.we = 1'b1;
        mem.waddr = rbase + 1'b1;
        mem.wdata = word[7:0];
        next_state = ST_NEXT;
      end
      ST_NEXT: begin
        if ((!is_read && !is_multi) || 16'(idx) + 16'h0001 == num) begin
          next_state = ST_HOLD;
        end else begin
          next_idx = idx + 1'b1;
          next_state = is_read ? ST_REQ : ST_RDHI;
        end
      end
      ST_HOLD: begin
        if (slave == SLAVE_BCAST) begin
          next_state = ST_RECV;
        end else if (idle_cnt == '0) begin
          next_tx_idx = '0;
          if (exc != EXC_NONE) begin
            next_tx_len = AW'(LEN_EXC);
          end else if (is_read) begin
            next_tx_len = AW'(POS_RDATA + 2 * int'(num[3:0]));
          end else begin
            next_tx_len = AW'(LEN_FIXED);
          end
          next_state = ST_TXLD;
        end
      end
      ST_TXLD: begin
        mem.raddr = tx_idx;
        next_state = ST_TXPUT;
      end
      ST_TXPUT: begin
        if (exc == EXC_NONE) begin
          next_tx_data = mem.rdata;
        end else if (int'(tx_idx) == POS_SLAVE) begin
          next_tx_data = slave;
        end else if (int'(tx_idx) == POS_FUNC) begin
          next_tx_data = func | EXC_FLAG;
        end else begin
          next_tx_data = exc;
        end
        next_tx_valid = 1'b1;
        next_tx_last = tx_idx == tx_len - 1'b1;
        next_state = ST_TXSEND;
      end
      ST_TXSEND: begin
        if (TX_READY) begin
          next_tx_valid = 1'b0;
          next_tx_last = 1'b0;
          next_tx_idx = tx_idx + 1'b1;
          next_state = tx_last ? ST_RECV : ST_TXLD;
        end
      end
      default: next_state = ST_RECV;
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      state <= ST_RECV;
      cnt <= '0;
      slave <= 8'h00;
      func <= 8'h00;
      bc <= 8'h00;
      exc <= EXC_NONE;
      data_hi <= 8'h00;
      addr <= 16'h0000;
      num <= 16'h0000;
      word <= 16'h0000;
      idx <= 4'h0;
      chk_ok <= 1'b0;
      idle_cnt <= '0;
      tx_idx <= '0;
      tx_len <= '0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_last <= 1'b0;
      par_req <= 1'b0;
      par_write <= 1'b0;
      par_addr <= 16'h0000;
      par_wdata <= 16'h0000;
      par_save <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      slave <= next_slave;
      func <= next_func;
      bc <= next_bc;
      exc <= next_exc;
      data_hi <= next_data_hi;
      addr <= next_addr;
      num <= next_num;
      word <= next_word;
      idx <= next_idx;
      chk_ok <= next_chk_ok;
      idle_cnt <= next_idle_cnt;
      tx_idx <= next_tx_idx;
      tx_len <= next_tx_len;
      tx_valid <= next_tx_valid;
      tx_data <= next_tx_data;
      tx_last <= next_tx_last;
      par_req <= next_par_req;
      par_write <= next_par_write;
      par_addr <= next_par_addr;
      par_wdata <= next_par_wdata;
      par_save <= next_par_save;
    end
  end

  assign TX_VALID = tx_valid;
  assign TX_DATA = tx_data;
  assign TX_LAST = tx_last;
  assign PAR_REQ = par_req;
  assign PAR_WRITE = par_write;
  assign PAR_ADDR = par_addr;
  assign PAR_WDATA = par_wdata;
  assign PAR_SAVE = par_save;

endmodule : mbs_slave

// ### mbs_slave_props.sv
`timescale 1ns/1ps
// ==========================================================
// Port-level checks of the slave command handler.
module mbs_slave_props
  import mbs_pkg::*;
#(
  parameter longint IDLE_CYCLES = IDLE_CYCLES_DEF
) (
  // Clock, reset and configuration
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic [7:0] SLAVE_ADDR,
  input wire logic POWER_LOSS_SAVE_SELECT,
  // Frame bytes
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_END,
  input wire logic TX_VALID,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_LAST,
  input wire logic TX_READY,
  // Parameter store
  input wire logic PAR_REQ,
  input wire logic PAR_WRITE,
  input wire logic [15:0] PAR_ADDR,
  input wire logic [15:0] PAR_WDATA,
  input wire logic PAR_SAVE,
  input wire logic PAR_ACK
);
  logic [5:0] rx_idx;
  logic [7:0] sl;
  logic [7:0] fn;
  logic [2:0] tx_pos;
  longint gap;
  logic seen;
  logic [15:0] last_a;

  // Tracks the request header, the reply position and the time since the frame end.
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      rx_idx <= 6'h00;
      sl <= 8'hFF;
      fn <= 8'h00;
      tx_pos <= 3'h0;
      gap <= 0;
      seen <= 1'b0;
      last_a <= 16'h0000;
    end else begin
      rx_idx <= RX_END ? 6'h00 : (RX_VALID ? rx_idx + 6'h01 : rx_idx);
      sl <= (RX_VALID && rx_idx == 6'h00) ? RX_DATA : sl;
      fn <= (RX_VALID && rx_idx == 6'h01) ? RX_DATA : fn;
      gap <= RX_END ? 0 : gap + 1;
      seen <= RX_END ? 1'b0 : (seen | $rose(PAR_REQ));
      last_a <= $rose(PAR_REQ) ? PAR_ADDR : last_a;
      if (RX_END || (TX_VALID && TX_READY && TX_LAST)) begin
        tx_pos <= 3'h0;
      end else if (TX_VALID && TX_READY && tx_pos != 3'h7) begin
        tx_pos <= tx_pos + 3'h1;
      end
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  sequence s_req_wait;
    PAR_REQ && !PAR_ACK;
  endsequence
  sequence s_req_done;
    PAR_REQ && PAR_ACK;
  endsequence
  sequence s_tx_wait;
    TX_VALID && !TX_READY;
  endsequence

  a_req_hold: assert property (s_req_wait |=> PAR_REQ && $stable(PAR_ADDR) && $stable(PAR_WDATA))
    else $error("store request changed before acknowledge");
  a_req_drop: assert property (s_req_done |=> !PAR_REQ)
    else $error("store request held after acknowledge");
  a_req_ascend: assert property ($rose(PAR_REQ) && seen |-> PAR_ADDR == last_a + 16'h0001)
    else $error("store addresses not consecutive");
  a_tx_hold: assert property (s_tx_wait |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST))
    else $error("reply byte changed before taken");
  a_save_vol: assert property (PAR_REQ && PAR_WRITE && fn == FN_WR1_VOL |-> !PAR_SAVE)
    else $error("volatile write marked for saving");
  a_save_keep: assert property (PAR_REQ && PAR_WRITE && fn == FN_WRN_KEEP |-> PAR_SAVE)
    else $error("keeping write not marked for saving");
  a_save_sel: assert property (PAR_REQ && PAR_WRITE && (fn == FN_WR1 || fn == FN_WRN)
    |-> PAR_SAVE == POWER_LOSS_SAVE_SELECT)
    else $error("save flag ignores selection");
  a_bcast_quiet: assert property (TX_VALID |-> sl != SLAVE_BCAST)
    else $error("reply sent to broadcast");
  a_reply_slave: assert property (TX_VALID && tx_pos == 3'h0 |-> TX_DATA == SLAVE_ADDR)
    else $error("reply carries wrong slave address");
  a_reply_func: assert property (TX_VALID && tx_pos == 3'h1 |-> TX_DATA == fn || TX_DATA == (fn | EXC_FLAG))
    else $error("reply carries wrong function code");
  a_idle_gap: assert property ($rose(TX_VALID) && tx_pos == 3'h0 |-> gap >= IDLE_CYCLES - 1)
    else $error("reply started before idle gap");
endmodule : mbs_slave_props

bind mbs_slave mbs_slave_props #(.IDLE_CYCLES(IDLE_CYCLES)) mbs_slave_props_inst (
  .CORE_CLK(CORE_CLK), .RESET(RESET), .SLAVE_ADDR(SLAVE_ADDR),
  .POWER_LOSS_SAVE_SELECT(POWER_LOSS_SAVE_SELECT), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA),
  .RX_END(RX_END), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_LAST(TX_LAST), .TX_READY(TX_READY),
  .PAR_REQ(PAR_REQ), .PAR_WRITE(PAR_WRITE), .PAR_ADDR(PAR_ADDR), .PAR_WDATA(PAR_WDATA),
  .PAR_SAVE(PAR_SAVE), .PAR_ACK(PAR_ACK)
);

// ### mbs_store_model.sv
`timescale 1ns/1ps
// ==========================================================
// Parameter store: answers after dly cycles and refuses fail_a with fail_c.
module mbs_store_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request
  input wire logic req,
  input wire logic write,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic save,
  // Behaviour control
  input wire logic [3:0] dly,
  input wire logic [15:0] fail_a,
  input wire logic [7:0] fail_c,
  // Answer
  output logic ack,
  output logic [15:0] rdata,
  output logic [7:0] exc
);
  logic [15:0] mem [logic [15:0]];
  logic [32:0] wr_q[$];
  logic [3:0] cnt;
  logic bad;

  initial begin
    ack = 1'b0;
    rdata = 16'h5A5A;
    exc = 8'hA5;
    cnt = 4'h0;
  end

  // Answer lines toggle outside the acknowledge cycle so stale values are never trusted.
  always @(posedge clk) begin
    bad = (addr == fail_a) && (fail_c != 8'h00);
    ack <= 1'b0;
    rdata <= ~rdata;
    exc <= ~exc;
    if (rst) begin
      cnt <= 4'h0;
    end else if (req && !ack) begin
      cnt <= cnt + 4'h1;
      if (cnt >= dly) begin
        cnt <= 4'h0;
        ack <= 1'b1;
        exc <= bad ? fail_c : 8'h00;
        rdata <= mem.exists(addr) ? mem[addr] : addr;
        if (write && !bad) begin
          mem[addr] = wdata;
          wr_q.push_back({save, addr, wdata});
        end
      end
    end
  end
endmodule : mbs_store_model

// ### modbus_slave_parameter_access_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; $display("mismatch %s exp %h got %h", n, e, g); end end
module modbus_slave_parameter_access_tb;
  import mbs_pkg::*;
  typedef logic [7:0] mbs_bytes_t[$];
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  logic clk = 1'b0, rst = 1'b1, sel = 1'b0, rxv = 1'b0, rxe = 1'b0, rxok = 1'b0, txr = 1'b1, stall = 1'b0;
  logic [7:0] rxd = 8'h00, fail_c = 8'h00, txd, pexc;
  logic [3:0] dly = 4'h0;
  logic [15:0] fail_a = 16'hFFFF, paddr, pwd, prd;
  logic txv, txl, preq, pwr, psave, pack;

  mbs_slave #(.IDLE_CYCLES(20)) mbs_slave_inst (
    .CORE_CLK(clk), .RESET(rst), .SLAVE_ADDR(8'h11), .POWER_LOSS_SAVE_SELECT(sel),
    .RX_VALID(rxv), .RX_DATA(rxd), .RX_END(rxe), .RX_CHECK_OK(rxok),
    .TX_VALID(txv), .TX_DATA(txd), .TX_LAST(txl), .TX_READY(txr),
    .PAR_REQ(preq), .PAR_WRITE(pwr), .PAR_ADDR(paddr), .PAR_WDATA(pwd), .PAR_SAVE(psave),
    .PAR_ACK(pack), .PAR_RDATA(prd), .PAR_EXC(pexc));
  mbs_store_model store_inst (.clk(clk), .rst(rst), .req(preq), .write(pwr), .addr(paddr), .wdata(pwd),
    .save(psave), .dly(dly), .fail_a(fail_a), .fail_c(fail_c), .ack(pack), .rdata(prd), .exc(pexc));

  initial begin
    forever #20 clk = ~clk;
  end
  always @(negedge clk) txr <= stall ? ~txr : 1'b1;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      complete_run();
    end
  end

  // ==========================================================
  // Sends a request frame and compares the whole reply.
  task automatic xfer(input mbs_bytes_t req, input logic ok, input mbs_bytes_t exp);
    mbs_bytes_t got;
    foreach (req[i]) begin
      @(negedge clk);
      rxv = 1'b1;
      rxd = req[i];
      @(negedge clk);
      rxv = 1'b0;
    end
    rxe = 1'b1;
    rxok = ok;
    @(negedge clk);
    rxe = 1'b0;
    for (int n = 0; n < 400; n++) begin
      @(posedge clk);
      if (txv && txr) begin
        got.push_back(txd);
        if (txl) break;
      end
    end
    `CHK("reply length", exp.size(), got.size())
    foreach (exp[i]) `CHK("reply byte", exp[i], got[i])
    repeat (2) @(negedge clk);
  endtask : xfer

  task automatic t_read;
    mbs_bytes_t e = '{8'h11, FN_READ, 8'h18};
    xfer('{8'h11, FN_READ, 8'h04, 8'h02, 8'h00, 8'h03}, 1'b1,
      '{8'h11, FN_READ, 8'h06, 8'h04, 8'h02, 8'h07, 8'hEB, 8'h04, 8'h04});
    `CHK("read stores nothing", 0, store_inst.wr_q.size())
    for (int i = 0; i < 12; i++) begin
      e.push_back(8'h05);
      e.push_back(8'(i));
    end
    stall = 1'b1;
    xfer('{8'h11, FN_READ, 8'h05, 8'h00, 8'h00, 8'h0C}, 1'b1, e);
  endtask : t_read

  task automatic t_write1;
    logic [7:0] f;
    for (int k = 0; k < 3; k++) begin
      f = (k == 2) ? FN_WR1_VOL : FN_WR1;
      sel = (k != 0);
      store_inst.wr_q.delete();
      xfer('{8'h11, f, 8'h10, 8'h06, 8'h00, 8'hC8}, 1'b1, '{8'h11, f, 8'h10, 8'h06, 8'h00, 8'hC8});
      `CHK("single address", 16'h1006, store_inst.wr_q[0][31:16])
      `CHK("single value", 16'h0064, store_inst.wr_q[0][15:0])
      `CHK("single save", (k == 1), store_inst.wr_q[0][32])
    end
  endtask : t_write1

  task automatic t_writen;
    logic [15:0] v [3] = '{16'h0001, 16'h07D0, 16'h0003};
    dly = 4'h5;
    store_inst.wr_q.delete();
    xfer('{8'h11, FN_WRN_KEEP, 8'h03, 8'h02, 8'h00, 8'h03, 8'h06, 8'h00, 8'h01, 8'h07, 8'hD0, 8'h00, 8'h03},
      1'b1, '{8'h11, FN_WRN_KEEP, 8'h03, 8'h02, 8'h00, 8'h03});
    `CHK("multi count", 3, store_inst.wr_q.size())
    foreach (v[i]) begin
      `CHK("multi address", 16'h0302 + 16'(i), store_inst.wr_q[i][31:16])
      `CHK("multi value", v[i], store_inst.wr_q[i][15:0])
      `CHK("multi save", 1'b1, store_inst.wr_q[i][32])
    end
    sel = 1'b0;
    fail_a = 16'h0404;
    fail_c = EXC_RUNNING;
    store_inst.wr_q.delete();
    xfer('{8'h11, FN_WRN, 8'h04, 8'h02, 8'h00, 8'h04, 8'h08, 8'h00, 8'h10, 8'h03, 8'hE8, 8'h00, 8'h01, 8'h00,
      8'h02}, 1'b1, '{8'h11, FN_WRN | EXC_FLAG, EXC_RUNNING});
    `CHK("stop count", 2, store_inst.wr_q.size())
    `CHK("offset value", 16'h0000, store_inst.wr_q[1][15:0])
    `CHK("select save", 1'b0, store_inst.wr_q[0][32])
    fail_c = 8'h00;
    dly = 4'h0;
  endtask : t_writen

  task automatic t_exc;
    mbs_bytes_t r;
    logic [7:0] c [7] = '{EXC_FUNC, EXC_COUNT, EXC_ADDR, EXC_RANGE, EXC_FRAME, EXC_COUNT, EXC_ADDR};
    logic [7:0] s [4] = '{EXC_FAIL, EXC_UNSUP, EXC_FIXED, EXC_PASSWORD};
    for (int k = 0; k < 7; k++) begin
      case (k)
        0: r = '{8'h11, 8'h05, 8'h00, 8'h00, 8'h00, 8'h01};
        1: r = '{8'h11, FN_READ, 8'h00, 8'h00, 8'h00, 8'h0D};
        2: r = '{8'h11, FN_READ, 8'h0C, 8'h00, 8'h00, 8'h01};
        3: r = '{8'h11, FN_WR1, 8'h04, 8'h03, 8'h07, 8'hD1};
        4: r = '{8'h11, FN_READ, 8'h00, 8'h00, 8'h00, 8'h01};
        5: r = '{8'h11, FN_WRN, 8'h00, 8'h00, 8'h00, 8'h05, 8'h0A};
        default: r = '{8'h11, FN_READ, 8'h18, 8'h00, 8'h00, 8'h01};
      endcase
      xfer(r, k != 4, '{8'h11, r[1] | EXC_FLAG, c[k]});
    end
    fail_a = 16'h0100;
    foreach (s[k]) begin
      fail_c = s[k];
      xfer('{8'h11, FN_WR1_VOL, 8'h01, 8'h00, 8'h00, 8'h00}, 1'b1, '{8'h11, 8'hC1, s[k]});
    end
    fail_c = 8'h00;
  endtask : t_exc

  task automatic t_bcast;
    store_inst.wr_q.delete();
    xfer('{8'h00, FN_WR1, 8'h02, 8'h05, 8'h12, 8'h34}, 1'b1, '{});
    `CHK("broadcast write", 16'h0205, store_inst.wr_q[0][31:16])
    xfer('{8'h12, FN_READ, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b1, '{});
  endtask : t_bcast

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_read();
    t_write1();
    t_writen();
    t_exc();
    t_bcast();
    complete_run();
  end
endmodule : modbus_slave_parameter_access_tb
